// ==== pkg/imd_pkg.sv ====
// constants shared by the diagnostics and io control block
package imd_pkg;
  // byte addresses, the word sits at the even one
  localparam logic [6:0] ADR_NVM_CNT = 7'h00;
  localparam logic [6:0] ADR_PIN_IO  = 7'h32;
  localparam logic [6:0] ADR_MISC    = 7'h34;
  localparam logic [6:0] ADR_DIAG    = 7'h3C;

  localparam logic [15:0] MISC_RST     = 16'h0006;
  localparam logic [15:0] PIN_IO_RST   = 16'h0000;
  localparam logic [15:0] DIAG_RST     = 16'h0000;
  localparam logic [15:0] NVM_CNT_RST  = 16'h0000;
  localparam logic [15:0] MISC_WR_MASK = 16'h0C47;
  localparam logic [15:0] PIN_WR_MASK  = 16'h0F0F;

  // misc_control fields
  localparam int MISC_DR_LINE  = 0;
  localparam int MISC_DR_POL   = 1;
  localparam int MISC_DR_EN    = 2;
  localparam int MISC_POP      = 6;
  localparam int MISC_SELFTEST = 10;
  localparam int MISC_CSUM     = 11;

  // diagnostic_flags fields
  localparam int DIAG_FLASH  = 2;
  localparam int DIAG_SPI    = 3;
  localparam int DIAG_OVR    = 4;
  localparam int DIAG_ST     = 5;
  localparam int DIAG_CSUM   = 6;
  localparam int DIAG_ALM1   = 8;
  localparam int DIAG_ALM2   = 9;
  localparam int DIAG_AXIS   = 10;

  // pin_io_control fields
  localparam int PIN_DIR = 0;
  localparam int PIN_LVL = 8;
  localparam int LINES   = 4;

  // spi word layout
  localparam int WORD_BITS = 16;
  localparam int SPI_RW    = 15;

  // timing
  localparam int CLK_MHZ      = 250;
  localparam int CSUM_TIME_MS = 20;
  localparam int CSUM_CYC     = CSUM_TIME_MS * CLK_MHZ * 1000;
  localparam int ST_STEP_NS   = 1000;
  localparam int ST_STEP_CYC  = (ST_STEP_NS * CLK_MHZ + 999) / 1000;

  // self test: three gyro then three accel axes
  localparam int ST_AXES = 6;
  localparam int ST_LAST = ST_AXES - 1;
  localparam int ST_GYRO = 3;
  localparam logic [15:0] GYRO_LO  = 16'h0010;
  localparam logic [15:0] GYRO_HI  = 16'h4000;
  localparam logic [15:0] ACCEL_LO = 16'h0010;
  localparam logic [15:0] ACCEL_HI = 16'h4000;

  // program memory summed by the checksum test
  localparam int PROG_AW    = 8;
  localparam int PROG_WORDS = 256;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CHECK  = 3'b100
  } imd_st_type;
endpackage

// ==== hdl/imd_spi_slave.sv ====
// spi mode 3 slave, oversampled by the system clock
module imd_spi_slave (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // pins
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  // word side
  input  wire logic [15:0] tx_word_i,
  input  wire logic        tx_load_i,
  output logic [15:0]      word_o,
  output logic             word_valid_o,
  output logic             frame_err_o
);
  logic [2:0]  s1_r;
  logic [2:0]  s2_r;
  logic [2:0]  s3_r;
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic [3:0]  cnt_r;

  wire cs_act  = ~s2_r[2];
  wire cs_fall = s3_r[2] & ~s2_r[2];
  wire cs_rise = ~s3_r[2] & s2_r[2];
  wire sck_up  = cs_act & s2_r[1] & ~s3_r[1];
  wire sck_dn  = cs_act & ~s2_r[1] & s3_r[1];
  wire last    = cnt_r == 4'(imd_pkg::WORD_BITS - 1);
  wire [15:0] rx_nxt = {rx_r[14:0], s2_r[0]};

  assign miso_o = tx_r[15];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
      s3_r <= 3'h7;
    end else begin
      s1_r <= {cs_n_i, sclk_i, mosi_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_r         <= 16'h0000;
      word_o       <= 16'h0000;
      word_valid_o <= 1'b0;
      cnt_r        <= 4'h0;
    end else begin
      word_valid_o <= sck_up & last;
      if (cs_fall) begin
        cnt_r <= 4'h0;
      end else if (sck_up) begin
        rx_r  <= rx_nxt;
        cnt_r <= cnt_r + 4'h1;
        if (last) begin
          word_o <= rx_nxt;
        end
      end
    end
  end

  // first falling edge of a word only launches the msb, so no shift there
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_r <= 16'h0000;
    end else if (cs_fall || tx_load_i) begin
      tx_r <= tx_word_i;
    end else if (sck_dn && cnt_r != 4'h0) begin
      tx_r <= {tx_r[14:0], 1'b0};
    end
  end

  // edge count not a whole number of words
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_err_o <= 1'b0;
    end else begin
      frame_err_o <= cs_rise & (cnt_r != 4'h0);
    end
  end
endmodule

// ==== hdl/imd_diag_io.sv ====
// diagnostics, self test, checksum and io line control behind the spi port

// Function
// - Writing misc bit 10 runs self test, windows each axis, reports diag bit 5.
// - Checksum bit 11 and self test bit 10 clear themselves when done.
// - misc_control resets to 0x0006: data ready on line one, active high.
// - misc bit 1 picks data ready polarity, 1 high while valid.
// - misc bit 2 enables data ready; bit 0 picks line two or one.
// - misc bit 6 enables point of percussion compensation.
// - Data ready shows invalid while output registers update.
// - Each diagnostic flag reads 1 for error or active, 0 normal.
// - Reading diagnostic_flags returns the flags, then clears all of them.
// - A persisting condition sets its flag again at end of next sample.
// - Diag bit 3 set when spi edges were not a multiple of 16.
// - Diag bits 15..13 accel Z,Y,X fail; bits 12..10 gyro Z,Y,X fail.
// - Diag bit 6 checksum, 4 overrange, 2 flash fail; 7,1,0 unused.
// - Read-only 16-bit counter counts flash writes from the three commands; writes in the same cycle count once.
// - misc bit 11 sums program memory, compares, sets diag bit 6; 20 ms.
// - Lines one, two: data ready beats alarm, alarm beats general io.
// - Line four serves external clock first; line three only general io.
// - pin_io_control bits 3..0 set direction of lines four..one, 1 output.
// - Bits 11..8 drive output levels; reads return sampled levels for input lines, stored levels for output lines.
module imd_diag_io #(
  parameter int CSUM_CYCLES = imd_pkg::CSUM_CYC
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // spi port
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  // io lines one to four
  input  wire logic [3:0]  io_i,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe_o,
  output logic             ext_sync_o,
  // sampling core
  input  wire logic        sample_tick_i,
  input  wire logic        update_busy_i,
  input  wire logic        ext_clk_sel_i,
  input  wire logic        overrange_i,
  output logic             pop_en_o,
  // alarms
  input  wire logic        alarm1_i,
  input  wire logic        alarm2_i,
  input  wire logic        alarm_out_en_i,
  input  wire logic        alarm_line_sel_i,
  input  wire logic        alarm_pol_i,
  // flash writes
  input  wire logic        flash_update_i,
  input  wire logic        restore_done_i,
  input  wire logic        bias_done_i,
  input  wire logic        flash_fail_i,
  // self test sensor access
  output logic             st_active_o,
  output logic [2:0]       st_axis_o,
  input  wire logic [15:0] st_resp_i,
  // program memory
  output logic             prog_rd_o,
  output logic [7:0]       prog_addr_o,
  input  wire logic [15:0] prog_data_i,
  input  wire logic [15:0] factory_sum_i
);
  localparam int CW = $clog2(CSUM_CYCLES + 1);

  function automatic logic [15:0] byte_wr(input logic [15:0] old, input logic [7:0] d,
                                          input logic hi, input logic [15:0] mask);
    logic [15:0] w;
    w = hi ? {d, old[7:0]} : {old[15:8], d};
    byte_wr = (w & mask) | (old & ~mask);
  endfunction

  // reset release
  logic [1:0] rst_sync_r;
  wire        rst_n = rst_sync_r[1];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // spi port
  logic [15:0] word;
  logic        word_valid;
  logic        frame_err;
  logic [15:0] tx_r;
  logic        tx_load_r;

  imd_spi_slave u_spi (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n),
    .cs_n_i       (cs_n_i),
    .sclk_i       (sclk_i),
    .mosi_i       (mosi_i),
    .miso_o       (miso_o),
    .tx_word_i    (tx_r),
    .tx_load_i    (tx_load_r),
    .word_o       (word),
    .word_valid_o (word_valid),
    .frame_err_o  (frame_err)
  );

  // registers
  logic [15:0] misc_r;
  logic [15:0] misc_nxt;
  logic [15:0] pin_r;
  logic [15:0] diag_r;
  logic [15:0] diag_nxt;
  logic [15:0] set_vec;
  logic [15:0] nvm_r;
  logic [3:0]  io_s1_r;
  logic [3:0]  io_s2_r;

  // word decode
  wire [6:0] adr    = word[14:8];
  wire       wr_en  = word_valid & word[imd_pkg::SPI_RW];
  wire       rd_en  = word_valid & ~word[imd_pkg::SPI_RW];
  wire       hit_mi = adr[6:1] == imd_pkg::ADR_MISC[6:1];
  wire       hit_pi = adr[6:1] == imd_pkg::ADR_PIN_IO[6:1];
  wire       hit_dg = adr[6:1] == imd_pkg::ADR_DIAG[6:1];
  wire       hit_nv = adr[6:1] == imd_pkg::ADR_NVM_CNT[6:1];
  wire       diag_clr = rd_en & hit_dg;

  // gpio direction and level fields
  wire [3:0] pin_dir = pin_r[imd_pkg::PIN_DIR +: imd_pkg::LINES];
  wire [3:0] pin_lvl = pin_r[imd_pkg::PIN_LVL +: imd_pkg::LINES];

  // inputs read their pin, outputs their stored level
  logic [15:0] pin_rd;
  always_comb begin
    pin_rd = 16'h0000;
    pin_rd[imd_pkg::PIN_DIR +: imd_pkg::LINES] = pin_dir;
    pin_rd[imd_pkg::PIN_LVL +: imd_pkg::LINES] = (pin_lvl & pin_dir) | (io_s2_r & ~pin_dir);
  end

  wire [15:0] rd_word = hit_mi ? misc_r :
                        hit_pi ? pin_rd :
                        hit_dg ? diag_r :
                        hit_nv ? nvm_r  : 16'h0000;

  // answer goes out in the next word of the frame
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_r      <= 16'h0000;
      tx_load_r <= 1'b0;
    end else begin
      tx_load_r <= word_valid;
      if (word_valid) begin
        tx_r <= rd_en ? rd_word : 16'h0000;
      end
    end
  end

  // self test engine
  imd_pkg::imd_st_type st_state_r;
  imd_pkg::imd_st_type st_state_nxt;
  logic [2:0]  st_axis_r;
  logic [7:0]  st_cnt_r;
  logic [5:0]  st_fail_r;
  logic [5:0]  st_res_r;
  wire         st_gyro = st_axis_r < 3'(imd_pkg::ST_GYRO);
  wire [15:0]  st_lo   = st_gyro ? imd_pkg::GYRO_LO : imd_pkg::ACCEL_LO;
  wire [15:0]  st_hi   = st_gyro ? imd_pkg::GYRO_HI : imd_pkg::ACCEL_HI;
  wire         st_bad  = (st_resp_i < st_lo) | (st_resp_i > st_hi);
  wire [5:0]   st_upd  = st_fail_r | (6'(st_bad) << st_axis_r);
  wire         st_step = st_cnt_r == 8'(imd_pkg::ST_STEP_CYC - 1);
  wire         st_last = st_axis_r == 3'(imd_pkg::ST_LAST);
  wire         st_done = (st_state_r == imd_pkg::ST_CHECK) & st_last;

  always_comb begin
    case (st_state_r)
      imd_pkg::ST_IDLE:   st_state_nxt = misc_r[imd_pkg::MISC_SELFTEST] ?
                                         imd_pkg::ST_SETTLE : imd_pkg::ST_IDLE;
      imd_pkg::ST_SETTLE: st_state_nxt = st_step ? imd_pkg::ST_CHECK : imd_pkg::ST_SETTLE;
      imd_pkg::ST_CHECK:  st_state_nxt = st_last ? imd_pkg::ST_IDLE : imd_pkg::ST_SETTLE;
      default:            st_state_nxt = imd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st_state_r <= imd_pkg::ST_IDLE;
      st_axis_r  <= 3'h0;
      st_cnt_r   <= 8'h00;
      st_fail_r  <= 6'h00;
      st_res_r   <= 6'h00;
    end else begin
      st_state_r <= st_state_nxt;
      st_cnt_r   <= (st_state_r == imd_pkg::ST_SETTLE) ? st_cnt_r + 8'h01 : 8'h00;
      if (st_state_r == imd_pkg::ST_IDLE) begin
        st_axis_r <= 3'h0;
        st_fail_r <= 6'h00;
      end else if (st_state_r == imd_pkg::ST_CHECK) begin
        st_axis_r <= st_axis_r + 3'h1;
        st_fail_r <= st_upd;
      end
      if (st_done) begin
        st_res_r <= st_upd;
      end
    end
  end

  assign st_active_o = st_state_r != imd_pkg::ST_IDLE;
  assign st_axis_o   = st_axis_r;

  // checksum engine: sums the memory, then waits out the full test time
  logic          cs_busy_r;
  logic [CW-1:0] cs_cnt_r;
  logic [15:0]   cs_sum_r;
  logic          cs_bad_r;
  wire           cs_done = cs_busy_r & (cs_cnt_r == CW'(CSUM_CYCLES - 1));
  wire           cs_acc  = cs_busy_r & (cs_cnt_r != '0) &
                           (cs_cnt_r <= CW'(imd_pkg::PROG_WORDS));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_busy_r <= 1'b0;
      cs_cnt_r  <= '0;
      cs_sum_r  <= 16'h0000;
      cs_bad_r  <= 1'b0;
    end else begin
      if (!cs_busy_r) begin
        cs_busy_r <= misc_r[imd_pkg::MISC_CSUM];
        cs_cnt_r  <= '0;
        cs_sum_r  <= 16'h0000;
      end else begin
        cs_busy_r <= ~cs_done;
        cs_cnt_r  <= cs_cnt_r + CW'(1);
      end
      if (cs_acc) begin
        cs_sum_r <= cs_sum_r + prog_data_i;
      end
      if (cs_done) begin
        cs_bad_r <= cs_sum_r != factory_sum_i;
      end
    end
  end

  assign prog_rd_o   = cs_busy_r & (cs_cnt_r < CW'(imd_pkg::PROG_WORDS));
  assign prog_addr_o = cs_cnt_r[imd_pkg::PROG_AW-1:0];

  // misc_control: done clears trigger, a fresh write still wins
  always_comb begin
    misc_nxt = misc_r;
    if (st_done) begin
      misc_nxt[imd_pkg::MISC_SELFTEST] = 1'b0;
    end
    if (cs_done) begin
      misc_nxt[imd_pkg::MISC_CSUM] = 1'b0;
    end
    if (wr_en && hit_mi) begin
      // unused bits are masked so a careless write cannot set them
      misc_nxt = byte_wr(misc_nxt, word[7:0], adr[0], imd_pkg::MISC_WR_MASK);
    end
  end

  // flags: persistent conditions reappear on each sample tick
  wire alm_any = alarm1_i | alarm2_i;
  wire st_any  = |st_res_r;
  always_comb begin
    set_vec = 16'h0000;
    if (sample_tick_i) begin
      set_vec[imd_pkg::DIAG_AXIS +: imd_pkg::ST_AXES] = st_res_r;
      set_vec[imd_pkg::DIAG_ST]   = st_any;
      set_vec[imd_pkg::DIAG_CSUM] = cs_bad_r;
      set_vec[imd_pkg::DIAG_OVR]  = overrange_i;
      set_vec[imd_pkg::DIAG_ALM1] = alarm1_i;
      set_vec[imd_pkg::DIAG_ALM2] = alarm2_i;
    end
    if (st_done) begin
      set_vec[imd_pkg::DIAG_AXIS +: imd_pkg::ST_AXES] = st_upd;
      set_vec[imd_pkg::DIAG_ST] = |st_upd;
    end
    if (cs_done) begin
      set_vec[imd_pkg::DIAG_CSUM] = cs_sum_r != factory_sum_i;
    end
    set_vec[imd_pkg::DIAG_SPI]   = set_vec[imd_pkg::DIAG_SPI] | frame_err;
    set_vec[imd_pkg::DIAG_FLASH] = set_vec[imd_pkg::DIAG_FLASH] | flash_fail_i;
  end

  // set beats the read clear so no event is lost
  assign diag_nxt = (diag_r & ~{16{diag_clr}}) | set_vec;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      misc_r <= imd_pkg::MISC_RST;
      pin_r  <= imd_pkg::PIN_IO_RST;
      diag_r <= imd_pkg::DIAG_RST;
      nvm_r  <= imd_pkg::NVM_CNT_RST;
    end else begin
      misc_r <= misc_nxt;
      diag_r <= diag_nxt;
      if (wr_en && hit_pi) begin
        pin_r <= byte_wr(pin_r, word[7:0], adr[0], imd_pkg::PIN_WR_MASK);
      end
      if (flash_update_i || restore_done_i || bias_done_i) begin
        nvm_r <= nvm_r + 16'h0001;
      end
    end
  end

  assign pop_en_o = misc_r[imd_pkg::MISC_POP];

  // io line arbitration
  wire       dr_en   = misc_r[imd_pkg::MISC_DR_EN];
  wire       dr_sel  = misc_r[imd_pkg::MISC_DR_LINE];
  wire       dr_ok   = ~update_busy_i;
  wire       dr_lvl  = misc_r[imd_pkg::MISC_DR_POL] ? dr_ok : ~dr_ok;
  wire       al_lvl  = alarm_pol_i ? alm_any : ~alm_any;
  wire [1:0] dr_own  = {dr_en & dr_sel, dr_en & ~dr_sel};
  wire [1:0] al_own  = ~dr_own & {2{alarm_out_en_i}} &
                       {alarm_line_sel_i, ~alarm_line_sel_i};
  wire [1:0] hi_own  = dr_own | al_own;
  // stored gpio bits stay, they are only masked off the pin
  wire [1:0] lo_oe   = hi_own | (~hi_own & pin_dir[1:0]);
  wire [1:0] lo_lvl  = ({2{dr_lvl}} & dr_own) | ({2{al_lvl}} & al_own) |
                       (pin_lvl[1:0] & ~hi_own);
  wire       l4_oe   = ~ext_clk_sel_i & pin_dir[3];
  wire [3:0] oe_nxt  = {l4_oe, pin_dir[2], lo_oe};
  wire [3:0] lvl_nxt = {pin_lvl[3:2], lo_lvl} & oe_nxt;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      io_s1_r    <= 4'h0;
      io_s2_r    <= 4'h0;
      io_o       <= 4'h0;
      io_oe_o    <= 4'h0;
      ext_sync_o <= 1'b0;
    end else begin
      io_s1_r    <= io_i;
      io_s2_r    <= io_s1_r;
      io_o       <= lvl_nxt;
      io_oe_o    <= oe_nxt;
      ext_sync_o <= ext_clk_sel_i & io_s2_r[3];
    end
  end
endmodule

// ==== sim/imd_spi_host.sv ====
// spi master model standing in for the host processor, mode 3
module imd_spi_host (
  // clock
  input  wire logic clock_i,
  // spi pins
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b0;
  end

  // clock stands high between frames; n below 16 makes a broken frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clock_i);
    #1;
    cs_n_o = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      mosi_o = w[15 - i];
      #40;
      sclk_o = 1'b1;
      r = {r[14:0], miso_i};
      #40;
    end
    cs_n_o = 1'b1;
    // released data line must not keep its last bit
    mosi_o = ~mosi_o;
    #40;
    @(posedge clock_i);
    #1;
  endtask
endmodule

// ==== sim/imd_diag_io_props.sv ====
// port level checks on the diagnostics and io control block
module imd_diag_io_props #(
  parameter int CSUM_CYCLES = imd_pkg::CSUM_CYC
) (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       rstn_i,
  // io lines
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  input wire logic       ext_sync_o,
  input wire logic       ext_clk_sel_i,
  // self test and checksum
  input wire logic       st_active_o,
  input wire logic [2:0] st_axis_o,
  input wire logic       prog_rd_o,
  input wire logic [7:0] prog_addr_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] st_cnt_r;
  logic [11:0] st_cnt_nxt;
  // length of the running self test, zero while idle
  assign st_cnt_nxt = st_active_o ? st_cnt_r + 12'h001 : 12'h000;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) st_cnt_r <= 12'h000;
    else st_cnt_r <= st_cnt_nxt;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  property p_oe_gate; (io_o & ~io_oe_o) == 4'h0; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("level on undriven line");
  property p_ext_in; ext_clk_sel_i && $past(ext_clk_sel_i) |-> !io_oe_o[3]; endproperty
  a_ext_in: assert property (p_ext_in) else $error("line four driven");
  property p_ext_sync; (ext_clk_sel_i && $stable(io_i[3])) [*8] |-> ext_sync_o == io_i[3];
  endproperty
  a_ext_sync: assert property (p_ext_sync) else $error("ext sync wrong");
  property p_cs_first; $rose(prog_rd_o) |-> prog_addr_o == 8'h00; endproperty
  a_cs_first: assert property (p_cs_first) else $error("sum start addr");
  property p_cs_step; prog_rd_o && $past(prog_rd_o) |-> prog_addr_o == $past(prog_addr_o) + 8'h01;
  endproperty
  a_cs_step: assert property (p_cs_step) else $error("sum addr step");
  property p_cs_end; $fell(prog_rd_o) |-> $past(prog_addr_o) == 8'hFF; endproperty
  a_cs_end: assert property (p_cs_end) else $error("sum end addr");
  property p_st_first; $rose(st_active_o) |-> st_axis_o == 3'h0; endproperty
  a_st_first: assert property (p_st_first) else $error("self test first axis");
  property p_st_step;
    st_active_o && $past(st_active_o) && $changed(st_axis_o) |->
      st_axis_o == $past(st_axis_o) + 3'h1;
  endproperty
  a_st_step: assert property (p_st_step) else $error("self test axis order");
  property p_st_hold; st_active_o && $changed(st_axis_o) |=> $stable(st_axis_o) [*8]; endproperty
  a_st_hold: assert property (p_st_hold) else $error("axis settle short");
  property p_st_len; $fell(st_active_o) |-> st_cnt_r >= 12'h5E1 && st_cnt_r <= 12'h5E4; endproperty
  a_st_len: assert property (p_st_len) else $error("self test length");

  c_st_done: cover property ($fell(st_active_o));
  c_cs_done: cover property ($fell(prog_rd_o));
  c_ext: cover property (ext_clk_sel_i && ext_sync_o);
endmodule

bind imd_diag_io imd_diag_io_props #(.CSUM_CYCLES(CSUM_CYCLES)) u_props (
  .clock_i(clock_i), .rstn_i(rstn_i), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
  .ext_sync_o(ext_sync_o), .ext_clk_sel_i(ext_clk_sel_i), .st_active_o(st_active_o),
  .st_axis_o(st_axis_o), .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o)
);

// ==== sim/imd_diag_io_bench.sv ====
// self-checking bench for the diagnostics and io control block
module imd_diag_io_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CSUM_SIM = 300;
  logic        clock_i, rstn_i, cs_n_i, sclk_i, mosi_i, miso_o, ext_sync_o, pop_en_o;
  logic        sample_tick_i, update_busy_i, ext_clk_sel_i, overrange_i, alarm1_i, alarm2_i;
  logic        alarm_out_en_i, alarm_line_sel_i, alarm_pol_i, flash_update_i, restore_done_i;
  logic        bias_done_i, flash_fail_i, st_active_o, prog_rd_o;
  logic [2:0]  st_axis_o;
  logic [3:0]  io_i, io_o, io_oe_o, ext_lvl;
  logic [7:0]  prog_addr_o;
  logic [15:0] st_resp_i, prog_data_i, factory_sum_i, rd_v;
  logic [15:0] resp [6];
  int          errors, samples_checked;

  imd_diag_io #(.CSUM_CYCLES(CSUM_SIM)) dut (
    .clock_i, .rstn_i, .cs_n_i, .sclk_i, .mosi_i, .miso_o, .io_i, .io_o, .io_oe_o,
    .ext_sync_o, .sample_tick_i, .update_busy_i, .ext_clk_sel_i, .overrange_i, .pop_en_o,
    .alarm1_i, .alarm2_i, .alarm_out_en_i, .alarm_line_sel_i, .alarm_pol_i, .flash_update_i,
    .restore_done_i, .bias_done_i, .flash_fail_i, .st_active_o, .st_axis_o, .st_resp_i,
    .prog_rd_o, .prog_addr_o, .prog_data_i, .factory_sum_i
  );
  imd_spi_host host (.clock_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i), .mosi_o(mosi_i), .miso_i(miso_o));

  // an enabled driver wins the wire, else the outside source
  assign io_i = (io_oe_o & io_o) | (~io_oe_o & ext_lvl);
  assign st_resp_i = resp[st_axis_o];
  // memory answers one cycle late; all ones while idle shows a late extra sum
  always @(posedge clock_i) prog_data_i <= prog_rd_o ? {8'h00, prog_addr_o} : 16'hFFFF;

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic tick();
    sample_tick_i = 1'b1;
    step(1);
    sample_tick_i = 1'b0;
    step(1);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  // even address carries the low byte
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] r;
    host.xfer({1'b1, a, v[7:0]}, 16, r);
    host.xfer({1'b1, a | 7'h01, v[15:8]}, 16, r);
  endtask
  // the answer arrives in the following word
  task automatic rdchk(input string what, input logic [6:0] a, input logic [15:0] exp);
    host.xfer({1'b0, a, 8'h00}, 16, rd_v);
    host.xfer(16'h0000, 16, rd_v);
    chk(what, exp, rd_v);
  endtask

  task automatic t_reset();
    chk("dr oe", 16'h0001, {14'h0000, io_oe_o[1:0]});
    chk("dr invalid", 16'h0000, {15'h0000, io_o[0]});
    update_busy_i = 1'b0;
    step(3);
    chk("dr valid", 16'h0001, {15'h0000, io_o[0]});
    update_busy_i = 1'b1;
    rdchk("misc rst", 7'h34, 16'h0006);
    rdchk("pin rst", 7'h32, 16'h0000);
    rdchk("diag rst", 7'h3C, 16'h0000);
    rdchk("cnt rst", 7'h00, 16'h0000);
    wr(7'h10, 16'h00A5);
    rdchk("unmapped", 7'h10, 16'h0000);
  endtask

  task automatic t_dready();
    logic [15:0] tab [6];
    logic [1:0]  oe;
    tab = '{16'h0006, 16'h0004, 16'h0007, 16'h0005, 16'h0002, 16'h0046};
    foreach (tab[i]) begin
      wr(7'h34, tab[i]);
      oe = tab[i][2] ? (tab[i][0] ? 2'b10 : 2'b01) : 2'b00;
      chk("dr enable", {14'h0000, oe}, {14'h0000, io_oe_o[1:0]});
      chk("dr level", {14'h0000, oe & {2{~tab[i][1]}}}, {14'h0000, io_o[1:0]});
      chk("pop", {15'h0000, tab[i][6]}, {15'h0000, pop_en_o});
      rdchk("misc rb", 7'h34, tab[i]);
    end
  endtask

  task automatic t_prio();
    wr(7'h34, 16'h0006);
    {alarm_out_en_i, alarm_line_sel_i, alarm_pol_i, alarm1_i, alarm2_i} = 5'h1F;
    wr(7'h32, 16'h000F);
    chk("oe all", 16'h000F, {12'h000, io_oe_o});
    chk("lvl alarm", 16'h0002, {12'h000, io_o});
    alarm_pol_i = 1'b0;
    wr(7'h32, 16'h0F0F);
    chk("lvl gpio", 16'h000C, {12'h000, io_o});
    rdchk("pin kept", 7'h32, 16'h0F0F);
    wr(7'h32, 16'h0F07);
    ext_clk_sel_i = 1'b1;
    ext_lvl = 4'h8;
    step(12);
    chk("line four oe", 16'h0000, {15'h0000, io_oe_o[3]});
    chk("ext sync", 16'h0001, {15'h0000, ext_sync_o});
    {alarm_out_en_i, alarm1_i, alarm2_i, ext_clk_sel_i} = 4'h0;
    ext_lvl = 4'hA;
    wr(7'h34, 16'h0002);
    wr(7'h32, 16'h0000);
    rdchk("pin in", 7'h32, 16'h0A00);
  endtask

  task automatic t_flags();
    {overrange_i, alarm1_i} = 2'h3;
    tick();
    {alarm1_i, flash_fail_i} = 2'h1;
    step(1);
    flash_fail_i = 1'b0;
    rdchk("flags", 7'h3C, 16'h0114);
    rdchk("flags clr", 7'h3C, 16'h0000);
    alarm2_i = 1'b1;
    tick();
    rdchk("flags again", 7'h3C, 16'h0210);
    {overrange_i, alarm2_i} = 2'h0;
    host.xfer(16'h3C00, 12, rd_v);
    rdchk("spi err", 7'h3C, 16'h0008);
  endtask

  task automatic t_count();
    flash_update_i = 1'b1;
    step(1);
    {flash_update_i, restore_done_i} = 2'h1;
    step(1);
    {restore_done_i, bias_done_i} = 2'h1;
    step(1);
    bias_done_i = 1'b0;
    wr(7'h00, 16'h0055);
    rdchk("nvm cnt", 7'h00, 16'h0003);
  endtask

  task automatic t_csum();
    logic [15:0] sum;
    sum = 16'h0000;
    for (int a = 0; a < 256; a++) sum += {8'h00, a[7:0]};
    for (int run = 0; run < 2; run++) begin
      factory_sum_i = sum + run[15:0];
      wr(7'h34, 16'h0806);
      step(CSUM_SIM + 20);
      rdchk("csum bit", 7'h34, 16'h0006);
      rdchk("csum flag", 7'h3C, {9'h000, run[0], 6'h00});
    end
  endtask

  task automatic t_self();
    logic [15:0] exp;
    for (int run = 0; run < 2; run++) begin
      resp = '{16'h0010, 16'h4000, 16'h1000, 16'h0010, 16'h2000, 16'h4000};
      if (run == 1) begin
        resp[1] = 16'h000F;
        resp[5] = 16'h4001;
      end
      exp = 16'h0000;
      foreach (resp[i]) if (resp[i] < 16'h0010 || resp[i] > 16'h4000) exp |= 16'h0400 << i;
      wr(7'h34, 16'h0406);
      chk("st active", 16'h0001, {15'h0000, st_active_o});
      for (int n = 0; n < 3000 && st_active_o === 1'b1; n++) step(1);
      rdchk("st bit", 7'h34, 16'h0006);
      rdchk("st diag", 7'h3C, exp | 16'h0020 & {16{|exp}});
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {rstn_i, sample_tick_i, ext_clk_sel_i, overrange_i, alarm1_i, alarm2_i} = 6'h00;
    {alarm_out_en_i, alarm_line_sel_i, alarm_pol_i, flash_update_i} = 4'h0;
    {restore_done_i, bias_done_i, flash_fail_i, update_busy_i} = 4'h1;
    {ext_lvl, factory_sum_i} = 20'h0_0000;
    resp = '{default: 16'h1000};
    errors = 0;
    samples_checked = 0;
    step(16);
    rstn_i = 1'b1;
    step(8);
    t_reset();
    t_dready();
    t_prio();
    t_flags();
    t_count();
    t_csum();
    t_self();
    results();
  end

  // a hung handshake ends the run as a failure
  initial begin
    #300_000;
    errors++;
    results();
  end
endmodule
